// *** design/rcr_pkg.sv ***
// Package of constants, types and helpers for the regulator control register bank
//
// Overview of operation
// - Reg1 sleep behaviour 00 selects image voltage, 01 disables output; 10/11 reserved.
// - Reg1 sleep trigger 00 uses register bit, 01..11 use low-power pins one..three.
// - Reg1 image code: 0.9V+50mV steps low half, 1.8V+100mV high half; default 1_1100.
// - State machine reset restores every regulator field to its fixed default.
// - Reg2 float bit clear discharges the disabled output; set leaves it floating.
// - With all four regulators disabled the Reg2 output is discharged regardless of float.
// - Reg2 voltage code uses the same encoding and applies only in regulator mode.
// - Reg2 fault always interrupts; action 00 none, 01 regulator off, 10/11 system off.
// - Reg2 startup slot: 0000 never, 0001..1110 slots 1..14, 1111 on entering ACTIVE.
// - Reg2 shutdown slot: 0001..1110 slots 1..14; 0000 and 1111 on entering OFF.
package rcr_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_REG1_LOW_POWER = 8'hca;
  localparam logic [7:0] IDX_REG2_CONTROL = 8'hcb;
  localparam logic [7:0] IDX_REG2_TIMEOUTS = 8'hcc;
  localparam logic [7:0] IDX_CTRL = 8'hd0;
  localparam logic [7:0] IDX_STATE = 8'hd1;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd2;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd3;

  // Field positions
  localparam int BEHAV_LSB = 12;
  localparam int TRIG_LSB = 8;
  localparam int SWITCH_BIT = 14;
  localparam int FLOAT_BIT = 10;
  localparam int ACTION_LSB = 14;
  localparam int START_LSB = 10;
  localparam int STOP_LSB = 6;
  localparam int CTRL_SLEEP_BIT = 0;

  // Writable bits of each register
  localparam logic [15:0] REG1_LP_MASK = 16'h331f;
  localparam logic [15:0] REG2_CTRL_MASK = 16'h441f;
  localparam logic [15:0] REG2_TO_MASK = 16'hffc0;
  localparam logic [15:0] CTRL_MASK = 16'h0001;

  // Defaults fixed by the device variant
  localparam logic [15:0] REG1_LP_DEFAULT = 16'h001c;
  localparam logic [15:0] REG2_CTRL_DEFAULT = 16'h001b;
  localparam logic [15:0] REG2_TO_DEFAULT = 16'h0000;

  localparam logic [1:0] BEHAV_IMAGE = 2'h0;
  localparam logic [1:0] BEHAV_OFF = 2'h1;
  localparam logic [1:0] TRIG_REG_BIT = 2'h0;
  localparam logic [1:0] TRIG_PIN_ONE = 2'h1;
  localparam logic [1:0] TRIG_PIN_TWO = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_REG_OFF = 2'h1;
  localparam logic [3:0] SLOT_NEVER = 4'h0;
  localparam logic [3:0] SLOT_STATE = 4'hf;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_UP = 1;
  localparam int IRQ_DOWN = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Voltage encoding in millivolts
  localparam int MV_LOW_BASE = 900;
  localparam int MV_LOW_STEP = 50;
  localparam int MV_HIGH_BASE = 1800;
  localparam int MV_HIGH_STEP = 100;

  typedef struct packed {
    logic sleep_active;
    logic disable_out;
    logic [4:0] code;
    logic [11:0] millivolt;
  } rcr_reg1_out_t;

  typedef struct packed {
    logic enable;
    logic discharge;
    logic switch_mode;
    logic [4:0] code;
    logic [11:0] millivolt;
  } rcr_reg2_out_t;

  typedef struct packed {
    logic strobe;
    logic [3:0] number;
    logic shutdown;
  } rcr_slot_t;

  function automatic logic [11:0] code_to_mv(input logic [4:0] code);
    int mv;
    mv = code[4] ? MV_HIGH_BASE + MV_HIGH_STEP * int'(code[3:0])
                 : MV_LOW_BASE + MV_LOW_STEP * int'(code[3:0]);
    return mv[11:0];
  endfunction

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    return res & mask;
  endfunction

endpackage

// *** design/rcr_regulator_ctrl_regs.sv ***
// Regulator control register bank with AXI4-Lite slave, sequencing and fault handling
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rcr_regulator_ctrl_regs
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AXI4-Lite write address and data
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [rcr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [rcr_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [rcr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [rcr_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Power state machine
  input wire logic SM_RESET,
  input wire rcr_pkg::rcr_slot_t SLOT,
  input wire logic ENTER_ACTIVE,
  input wire logic ENTER_OFF,
  output logic SYS_SHUTDOWN_REQ,
  // Pins from outside the clock domain
  input wire logic LOW_POWER_PIN_ONE,
  input wire logic LOW_POWER_PIN_TWO,
  input wire logic LOW_POWER_PIN_THREE,
  input wire logic REG2_FAULT,
  // Other regulators
  input wire logic [4:0] REG1_NORMAL_CODE,
  input wire logic REG1_ON,
  input wire logic REG3_ON,
  input wire logic REG4_ON,
  // Regulator controls and interrupt
  output rcr_pkg::rcr_reg1_out_t REG1_OUT,
  output rcr_pkg::rcr_reg2_out_t REG2_OUT,
  output logic IRQ
);
  import rcr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] reg1_low_power_r;
  logic [15:0] reg2_control_r;
  logic [15:0] reg2_timeouts_r;
  logic [15:0] ctrl_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  logic [1:0] reg1_sleep_behaviour;
  logic [1:0] reg1_sleep_trigger_sel;
  logic [4:0] reg1_image_voltage;
  logic reg2_switch_mode;
  logic reg2_output_float;
  logic [4:0] reg2_voltage_code;
  logic [1:0] reg2_fault_action;
  logic [3:0] reg2_startup_slot;
  logic [3:0] reg2_shutdown_slot;

  assign reg1_sleep_behaviour = reg1_low_power_r[BEHAV_LSB +: 2];
  assign reg1_sleep_trigger_sel = reg1_low_power_r[TRIG_LSB +: 2];
  assign reg1_image_voltage = reg1_low_power_r[4:0];
  assign reg2_switch_mode = reg2_control_r[SWITCH_BIT];
  assign reg2_output_float = reg2_control_r[FLOAT_BIT];
  assign reg2_voltage_code = reg2_control_r[4:0];
  assign reg2_fault_action = reg2_timeouts_r[ACTION_LSB +: 2];
  assign reg2_startup_slot = reg2_timeouts_r[START_LSB +: 4];
  assign reg2_shutdown_slot = reg2_timeouts_r[STOP_LSB +: 4];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;
  logic [3:0] pin_flt_r;
  logic fault_rise;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      pin_s3_r <= 4'h0;
      pin_flt_r <= 4'h0;
    end
    else
    begin
      pin_s1_r <= {REG2_FAULT, LOW_POWER_PIN_THREE, LOW_POWER_PIN_TWO, LOW_POWER_PIN_ONE};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r)
      begin
        pin_flt_r <= pin_s3_r;
      end
    end
  end

  // Filtered fault level rises once the second and third stages agree high
  assign fault_rise = (pin_s2_r[3] == pin_s3_r[3]) && pin_s3_r[3] && !pin_flt_r[3];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic [7:0] wr_idx;
  logic wr_hit;

  assign do_write = aw_got_r && w_got_r && !S_AXI_BVALID;
  assign wr_idx = aw_addr_r[ADDR_W-1:2];
  assign wr_hit = (wr_idx == IDX_REG1_LOW_POWER) || (wr_idx == IDX_REG2_CONTROL) ||
                  (wr_idx == IDX_REG2_TIMEOUTS) || (wr_idx == IDX_CTRL) ||
                  (wr_idx == IDX_STATE) || (wr_idx == IDX_IRQ_STATUS) || (wr_idx == IDX_IRQ_MASK);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_got_r <= 1'b0;
      aw_addr_r <= '0;
      S_AXI_AWREADY <= 1'b1;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_got_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      aw_got_r <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      w_got_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_got_r <= 1'b1;
      w_data_r <= S_AXI_WDATA;
      w_strb_r <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      w_got_r <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      reg1_low_power_r <= REG1_LP_DEFAULT;
      reg2_control_r <= REG2_CTRL_DEFAULT;
      reg2_timeouts_r <= REG2_TO_DEFAULT;
    end
    else if (SM_RESET)
    begin
      reg1_low_power_r <= REG1_LP_DEFAULT;
      reg2_control_r <= REG2_CTRL_DEFAULT;
      reg2_timeouts_r <= REG2_TO_DEFAULT;
    end
    else if (do_write)
    begin
      if (wr_idx == IDX_REG1_LOW_POWER)
      begin
        reg1_low_power_r <= merge(reg1_low_power_r, w_data_r, w_strb_r, REG1_LP_MASK);
      end
      if (wr_idx == IDX_REG2_CONTROL)
      begin
        reg2_control_r <= merge(reg2_control_r, w_data_r, w_strb_r, REG2_CTRL_MASK);
      end
      if (wr_idx == IDX_REG2_TIMEOUTS)
      begin
        reg2_timeouts_r <= merge(reg2_timeouts_r, w_data_r, w_strb_r, REG2_TO_MASK);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_r <= 16'h0000;
      irq_mask_r <= '0;
    end
    else if (do_write)
    begin
      if (wr_idx == IDX_CTRL)
      begin
        ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r, CTRL_MASK);
      end
      if (wr_idx == IDX_IRQ_MASK && w_strb_r[0])
      begin
        irq_mask_r <= w_data_r[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep selection for regulator 1
  // ----------------------------------------------------------------
  logic sleep_sel;

  always_comb
  begin
    unique case (reg1_sleep_trigger_sel)
      TRIG_REG_BIT: sleep_sel = ctrl_r[CTRL_SLEEP_BIT];
      TRIG_PIN_ONE: sleep_sel = pin_flt_r[0];
      TRIG_PIN_TWO: sleep_sel = pin_flt_r[1];
      default: sleep_sel = pin_flt_r[2];
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG1_OUT <= '0;
    end
    else
    begin
      REG1_OUT.sleep_active <= sleep_sel;
      REG1_OUT.disable_out <= sleep_sel && (reg1_sleep_behaviour == BEHAV_OFF);
      if (sleep_sel && reg1_sleep_behaviour == BEHAV_IMAGE)
      begin
        REG1_OUT.code <= reg1_image_voltage;
        REG1_OUT.millivolt <= code_to_mv(reg1_image_voltage);
      end
      else
      begin
        REG1_OUT.code <= REG1_NORMAL_CODE;
        REG1_OUT.millivolt <= code_to_mv(REG1_NORMAL_CODE);
      end
    end
  end

  // ----------------------------------------------------------------
  // Regulator 2 sequencing and fault action
  // ----------------------------------------------------------------
  logic start_now;
  logic stop_now;
  logic slot_up;
  logic slot_down;
  logic all_off;

  assign slot_up = SLOT.strobe && !SLOT.shutdown;
  assign slot_down = SLOT.strobe && SLOT.shutdown;
  assign start_now = (slot_up && reg2_startup_slot != SLOT_NEVER && reg2_startup_slot != SLOT_STATE &&
                      SLOT.number == reg2_startup_slot) ||
                     (ENTER_ACTIVE && reg2_startup_slot == SLOT_STATE);
  assign stop_now = (slot_down && reg2_shutdown_slot != SLOT_NEVER && reg2_shutdown_slot != SLOT_STATE &&
                     SLOT.number == reg2_shutdown_slot) ||
                    (ENTER_OFF && (reg2_shutdown_slot == SLOT_NEVER ||
                                   reg2_shutdown_slot == SLOT_STATE));
  assign all_off = !REG2_OUT.enable && !REG1_ON && !REG3_ON && !REG4_ON;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG2_OUT.enable <= 1'b0;
    end
    else if (SM_RESET)
    begin
      REG2_OUT.enable <= 1'b0;
    end
    else if (fault_rise && reg2_fault_action == ACT_REG_OFF)
    begin
      REG2_OUT.enable <= 1'b0;
    end
    else if (stop_now)
    begin
      REG2_OUT.enable <= 1'b0;
    end
    else if (start_now)
    begin
      REG2_OUT.enable <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG2_OUT.discharge <= 1'b1;
      REG2_OUT.switch_mode <= 1'b0;
      REG2_OUT.code <= '0;
      REG2_OUT.millivolt <= '0;
    end
    else
    begin
      REG2_OUT.discharge <= !REG2_OUT.enable && (!reg2_output_float || all_off);
      REG2_OUT.switch_mode <= reg2_switch_mode;
      REG2_OUT.code <= reg2_voltage_code;
      REG2_OUT.millivolt <= reg2_switch_mode ? 12'h000 : code_to_mv(reg2_voltage_code);
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SYS_SHUTDOWN_REQ <= 1'b0;
    end
    else
    begin
      SYS_SHUTDOWN_REQ <= fault_rise && reg2_fault_action[1];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set[IRQ_FAULT] = fault_rise;
  assign irq_set[IRQ_UP] = start_now && !REG2_OUT.enable && !SM_RESET;
  assign irq_set[IRQ_DOWN] = stop_now && REG2_OUT.enable;
  assign irq_clr = (do_write && wr_idx == IDX_IRQ_STATUS && w_strb_r[0]) ? w_data_r[IRQ_W-1:0] : '0;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_status_r <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      IRQ <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_hit;

  assign rd_idx = S_AXI_ARADDR[ADDR_W-1:2];

  always_comb
  begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_REG1_LOW_POWER: rd_data[15:0] = reg1_low_power_r;
      IDX_REG2_CONTROL: rd_data[15:0] = reg2_control_r;
      IDX_REG2_TIMEOUTS: rd_data[15:0] = reg2_timeouts_r;
      IDX_CTRL: rd_data[15:0] = ctrl_r;
      IDX_STATE: rd_data[4:0] = {REG2_OUT.discharge, REG2_OUT.enable, REG1_OUT.disable_out,
                                 REG1_OUT.sleep_active, pin_flt_r[3]};
      IDX_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_status_r;
      IDX_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// *** tb/rcr_regulator_ctrl_regs_props.sv ***
// Checker of the regulator control register bank outputs
`timescale 1ns/1ps
module rcr_regulator_ctrl_regs_props
(
  // Clock, reset, sequencer and Reg2 fault
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SM_RESET,
  input wire rcr_pkg::rcr_slot_t SLOT,
  input wire logic ENTER_ACTIVE,
  input wire logic ENTER_OFF,
  input wire logic REG2_FAULT,
  input wire logic SYS_SHUTDOWN_REQ,
  // Regulators
  input wire logic [4:0] REG1_NORMAL_CODE,
  input wire logic REG1_ON,
  input wire logic REG3_ON,
  input wire logic REG4_ON,
  input wire rcr_pkg::rcr_reg1_out_t REG1_OUT,
  input wire rcr_pkg::rcr_reg2_out_t REG2_OUT
);
  import rcr_pkg::*;
  logic start_r;
  logic stop_r;
  logic all_off;

  function automatic logic [11:0] to_mv(input logic [4:0] c);
    return c[4] ? 12'h708 + 12'h064 * {8'h00, c[3:0]} : 12'h384 + 12'h032 * {8'h00, c[3:0]};
  endfunction

  // Start and stop causes seen one cycle earlier
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end
    else
    begin
      start_r <= (SLOT.strobe && !SLOT.shutdown) || ENTER_ACTIVE;
      stop_r <= (SLOT.strobe && SLOT.shutdown) || ENTER_OFF || SM_RESET;
    end
  end

  assign all_off = !REG2_OUT.enable && !REG1_ON && !REG3_ON && !REG4_ON;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  reg1_volt_map_a: assert property ($past(RST_N) |-> REG1_OUT.millivolt == to_mv(REG1_OUT.code))
    else $error("reg1 millivolt does not match code");
  reg2_volt_map_a: assert property ($past(RST_N) && !REG2_OUT.switch_mode |-> REG2_OUT.millivolt == to_mv(REG2_OUT.code))
    else $error("reg2 millivolt does not match code");
  switch_no_volt_a: assert property (REG2_OUT.switch_mode |-> REG2_OUT.millivolt == 12'h000)
    else $error("switch mode shows a voltage");
  all_off_dis_a: assert property (all_off ##1 all_off |-> REG2_OUT.discharge)
    else $error("all regulators off without discharge");
  normal_code_a: assert property ($past(RST_N) && !REG1_OUT.sleep_active |-> REG1_OUT.code == $past(REG1_NORMAL_CODE))
    else $error("reg1 code not normal outside sleep");
  disable_in_sleep_a: assert property (REG1_OUT.disable_out |-> REG1_OUT.sleep_active)
    else $error("reg1 disabled outside sleep");
  start_cause_a: assert property ($rose(REG2_OUT.enable) |-> start_r)
    else $error("reg2 started without start event");
  stop_cause_a: assert property ($fell(REG2_OUT.enable) |-> stop_r || REG2_FAULT)
    else $error("reg2 stopped without stop event");
  sys_off_pulse_a: assert property (SYS_SHUTDOWN_REQ |-> REG2_FAULT ##1 !SYS_SHUTDOWN_REQ)
    else $error("system shutdown request without fault or too long");

  start_c: cover property ($rose(REG2_OUT.enable));
  stop_c: cover property ($fell(REG2_OUT.enable));
  sys_off_c: cover property (SYS_SHUTDOWN_REQ);
endmodule

bind rcr_regulator_ctrl_regs rcr_regulator_ctrl_regs_props rcr_regulator_ctrl_regs_props_i (.CLK(CLK), .RST_N(RST_N),
  .SM_RESET(SM_RESET), .SLOT(SLOT), .ENTER_ACTIVE(ENTER_ACTIVE), .ENTER_OFF(ENTER_OFF), .REG2_FAULT(REG2_FAULT),
  .SYS_SHUTDOWN_REQ(SYS_SHUTDOWN_REQ), .REG1_NORMAL_CODE(REG1_NORMAL_CODE), .REG1_ON(REG1_ON), .REG3_ON(REG3_ON),
  .REG4_ON(REG4_ON), .REG1_OUT(REG1_OUT), .REG2_OUT(REG2_OUT));

// *** tb/rcr_regulator_ctrl_regs_tb_top.sv ***
// Self-checking testbench of the regulator control register bank
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module rcr_regulator_ctrl_regs_tb_top;
  import rcr_pkg::*;
  logic CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic SM_RESET, ENTER_ACTIVE, ENTER_OFF, SYS_SHUTDOWN_REQ, REG2_FAULT, REG1_ON, IRQ;
  logic [9:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  logic [3:0] strb, s;
  logic [2:0] pins;
  logic [4:0] REG1_NORMAL_CODE, c;
  rcr_slot_t SLOT;
  rcr_reg1_out_t REG1_OUT;
  rcr_reg2_out_t REG2_OUT;
  int fails = 0;
  int tests_run = 0;
  int n_sd = 0;

  rcr_regulator_ctrl_regs rcr_regulator_ctrl_regs_i (.CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWPROT(3'b000),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(strb),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARPROT(3'b000),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .SM_RESET(SM_RESET), .SLOT(SLOT), .ENTER_ACTIVE(ENTER_ACTIVE), .ENTER_OFF(ENTER_OFF),
    .SYS_SHUTDOWN_REQ(SYS_SHUTDOWN_REQ), .LOW_POWER_PIN_ONE(pins[0]), .LOW_POWER_PIN_TWO(pins[1]),
    .LOW_POWER_PIN_THREE(pins[2]), .REG2_FAULT(REG2_FAULT), .REG1_NORMAL_CODE(REG1_NORMAL_CODE), .REG1_ON(REG1_ON),
    .REG3_ON(1'b0), .REG4_ON(1'b0), .REG1_OUT(REG1_OUT), .REG2_OUT(REG2_OUT), .IRQ(IRQ));

  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  always @(posedge CLK)
    if (SYS_SHUTDOWN_REQ === 1'b1)
      n_sd++;

  function automatic logic [11:0] mv_of(input logic [4:0] v);
    return v[4] ? 12'h708 + 12'h064 * {8'h00, v[3:0]} : 12'h384 + 12'h032 * {8'h00, v[3:0]};
  endfunction

  // One AXI4-Lite write or read, each channel held until its own handshake
  task automatic bus(input bit we, input logic [7:0] idx, input logic [31:0] d);
    bit a;
    bit w;
    bit done;
    @(posedge CLK);
    a = 1'b1;
    w = we;
    done = 1'b0;
    if (we)
    begin
      {S_AXI_AWADDR, S_AXI_WDATA} <= {idx, 2'b00, d};
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    end
    else
    begin
      S_AXI_ARADDR <= {idx, 2'b00};
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    end
    while (!done)
    begin
      @(posedge CLK);
      if (a && (we ? S_AXI_AWREADY : S_AXI_ARREADY))
      begin
        a = 1'b0;
        {S_AXI_AWVALID, S_AXI_ARVALID} <= 2'b00;
      end
      if (w && S_AXI_WREADY)
      begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
      if (we ? S_AXI_BVALID : S_AXI_RVALID)
      begin
        done = 1'b1;
        resp = we ? S_AXI_BRESP : S_AXI_RRESP;
        q = S_AXI_RDATA;
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'b00;
      end
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask

  // One-cycle pulse of {SM_RESET, ENTER_OFF, ENTER_ACTIVE} and SLOT
  task automatic ev(input logic [2:0] e, input rcr_slot_t sl);
    @(posedge CLK);
    {SM_RESET, ENTER_OFF, ENTER_ACTIVE, SLOT} <= {e, sl};
    @(posedge CLK);
    {SM_RESET, ENTER_OFF, ENTER_ACTIVE, SLOT} <= '0;
    tick(2);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #400000;
    fails++;
    wrap_up;
  end

  initial
  begin
    {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, SM_RESET, ENTER_ACTIVE} = '0;
    {ENTER_OFF, REG2_FAULT, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, SLOT, pins} = '0;
    {REG1_ON, REG1_NORMAL_CODE, strb} = {1'b1, 5'h08, 4'hf};
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    // Defaults, writable bits, byte strobes, unmapped index
    bus(0, IDX_REG1_LOW_POWER, 0);
    `CHK(q, 32'h0000_001c)
    bus(0, IDX_REG2_CONTROL, 0);
    `CHK(q, 32'h0000_001b)
    bus(1, IDX_REG1_LOW_POWER, 32'hffff_ffff);
    bus(0, IDX_REG1_LOW_POWER, 0);
    `CHK(q, 32'h0000_331f)
    bus(1, IDX_REG2_TIMEOUTS, 32'hffff_ffff);
    strb <= 4'h1;
    bus(1, IDX_REG2_TIMEOUTS, 0);
    strb <= 4'hf;
    bus(0, IDX_REG2_TIMEOUTS, 0);
    `CHK(q, 32'h0000_ff00)
    bus(1, 8'h00, 1);
    `CHK(resp, RESP_SLVERR)
    bus(0, 8'h00, 0);
    `CHK({q, resp}, {32'h0, RESP_SLVERR})
    // Voltage encoding at both ends of each half, then switch mode
    for (int k = 0; k < 4; k++)
    begin
      c = {k[1], {4{k[0]}}};
      bus(1, IDX_REG2_CONTROL, {27'h0, c});
      tick(2);
      `CHK(REG2_OUT.millivolt, mv_of(c))
    end
    bus(1, IDX_REG2_CONTROL, 32'h0000_4010);
    tick(2);
    `CHK({REG2_OUT.millivolt, REG2_OUT.code}, {12'h000, 5'h10})
    // Slot sequencing at slots 1 and 14, wrong direction and wrong slot ignored
    for (int k = 0; k < 2; k++)
    begin
      s = k ? 4'he : 4'h1;
      bus(1, IDX_REG2_TIMEOUTS, {18'h0, s, s, 6'h00});
      ev(3'b000, '{1'b1, s, 1'b1});
      `CHK(REG2_OUT.enable, 1'b0)
      ev(3'b000, '{1'b1, s, 1'b0});
      `CHK({REG2_OUT.enable, REG2_OUT.discharge}, 2'b10)
      ev(3'b000, '{1'b1, s - 4'h1, 1'b1});
      `CHK(REG2_OUT.enable, 1'b1)
      ev(3'b000, '{1'b1, s, 1'b1});
      `CHK({REG2_OUT.enable, REG2_OUT.discharge}, 2'b01)
    end
    // Interrupt masked, unmasked, cleared
    bus(0, IDX_IRQ_STATUS, 0);
    `CHK({q, IRQ}, {32'h0000_0006, 1'b0})
    bus(1, IDX_IRQ_MASK, 7);
    tick(2);
    `CHK(IRQ, 1'b1)
    bus(1, IDX_IRQ_STATUS, 6);
    tick(2);
    `CHK(IRQ, 1'b0)
    // Floating output, then all regulators off
    bus(1, IDX_REG2_CONTROL, 32'h0000_041b);
    tick(2);
    `CHK(REG2_OUT.discharge, 1'b0)
    @(posedge CLK);
    REG1_ON <= 1'b0;
    tick(3);
    `CHK(REG2_OUT.discharge, 1'b1)
    @(posedge CLK);
    REG1_ON <= 1'b1;
    // Start on ACTIVE, stop on OFF for shutdown codes 0000 and 1111
    for (int k = 0; k < 2; k++)
    begin
      bus(1, IDX_REG2_TIMEOUTS, k ? 32'h0000_3fc0 : 32'h0000_3c00);
      ev(3'b001, '0);
      `CHK(REG2_OUT.enable, 1'b1)
      ev(3'b010, '0);
      `CHK(REG2_OUT.enable, 1'b0)
    end
    ev(3'b001, '0);
    ev(3'b100, '0);
    `CHK(REG2_OUT.enable, 1'b0)
    bus(0, IDX_REG2_TIMEOUTS, 0);
    `CHK(q, 32'h0000_0000)
    bus(0, IDX_REG2_CONTROL, 0);
    `CHK(q, 32'h0000_001b)
    bus(1, IDX_REG2_TIMEOUTS, 0);
    ev(3'b001, '{1'b1, 4'h0, 1'b0});
    `CHK(REG2_OUT.enable, 1'b0)
    // Fault actions none, regulator off, system off
    for (int k = 0; k < 3; k++)
    begin
      bus(1, IDX_REG2_TIMEOUTS, {16'h0, k[1:0], 14'h3c00});
      ev(3'b001, '0);
      bus(1, IDX_IRQ_STATUS, 7);
      n_sd = 0;
      @(posedge CLK);
      REG2_FAULT <= 1'b1;
      tick(8);
      `CHK({REG2_OUT.enable, IRQ}, {k != 1, 1'b1})
      `CHK(n_sd, k / 2)
      bus(0, IDX_IRQ_STATUS, 0);
      `CHK(q[0], 1'b1)
      @(posedge CLK);
      REG2_FAULT <= 1'b0;
      tick(6);
    end
    // Sleep by register bit, then by each low-power pin
    bus(1, IDX_REG1_LOW_POWER, 32'h0000_0005);
    bus(1, IDX_CTRL, 1);
    tick(2);
    `CHK({REG1_OUT.code, REG1_OUT.millivolt}, {5'h05, mv_of(5'h05)})
    bus(1, IDX_CTRL, 0);
    tick(2);
    `CHK(REG1_OUT.code, 5'h08)
    for (int k = 1; k < 4; k++)
    begin
      bus(1, IDX_REG1_LOW_POWER, {22'h0, k[1:0], 8'h05});
      @(posedge CLK);
      pins <= ~(3'b001 << (k - 1));
      tick(6);
      `CHK(REG1_OUT.code, 5'h08)
      @(posedge CLK);
      pins <= 3'b001 << (k - 1);
      tick(6);
      `CHK(REG1_OUT.code, 5'h05)
    end
    @(posedge CLK);
    pins <= 3'b000;
    bus(1, IDX_CTRL, 1);
    bus(1, IDX_REG1_LOW_POWER, 32'h0000_1005);
    tick(2);
    `CHK(REG1_OUT.disable_out, 1'b1)
    bus(1, IDX_REG1_LOW_POWER, 32'h0000_2005);
    tick(2);
    `CHK({REG1_OUT.disable_out, REG1_OUT.code}, {1'b0, 5'h08})
    wrap_up;
  end
endmodule
